// *** rtl/pll_status_interrupt_logic.sv ***
// Status latches, interrupt enables and active-low interrupt of the PLL block
// Function
// - Output-PLL unlock latch gated onto interrupt
// - VCXO-PLL unlock latch gated onto interrupt
// - Per-input loss-of-signal latch gated onto interrupt
// - Reference latch change gated onto interrupt
// - Holdover latch gated onto interrupt
// - Output-PLL lock latch, write one clears
// - VCXO-PLL lock latch, write one clears
// - Per-input activity latch, write one clears
// - Selected input reported as two bits
// - Live output-PLL lock bit, read only
// - All interrupt enables reset to zero
// - Live per-input activity bits
// - Reference latch reads zero after loss
// - Holdover latched and live, zero means holdover
// - Calibration bit high while calibrating
module pll_status_interrupt_logic (
    // Clock and reset
    input  wire logic                       ref_clk_in,
    input  wire logic                       reset_n_in,
    // Live status from the analog side, asynchronous
    input  wire pll_status_pkg::live_status_t live_status_in,
    // Register access from the serial port engine, same clock
    input  wire pll_status_pkg::reg_req_t   reg_req_in,
    output logic [7:0]                      reg_rdata_out,
    // Interrupt pin, active low
    output logic                            irq_out_low_n_out
);

    localparam int N = pll_status_pkg::NUM_INPUTS;

    // Synchronised live status
    logic [$bits(pll_status_pkg::live_status_t)-1:0] live_flat;
    pll_status_pkg::live_status_t                     live;

    status_sync #(
        .WIDTH     ($bits(pll_status_pkg::live_status_t)),
        .RESET_VAL (1'b0)
    ) u_sync (
        .ref_clk_in (ref_clk_in),
        .reset_n_in (reset_n_in),
        .async_in   (live_status_in),
        .level_out  (live_flat)
    );
    assign live = pll_status_pkg::live_status_t'(live_flat);

    // Interrupt enables
    logic                  irq_en_out_pll_unlock_r,  irq_en_out_pll_unlock_nxt;
    logic                  irq_en_vcxo_pll_unlock_r, irq_en_vcxo_pll_unlock_nxt;
    logic [N-1:0]          irq_en_input_los_r,       irq_en_input_los_nxt;
    logic                  irq_en_reference_r,       irq_en_reference_nxt;
    logic                  irq_en_holdover_r,        irq_en_holdover_nxt;
    // Latched status, 1 means clean
    logic                  latched_out_pll_locked_r,  latched_out_pll_locked_nxt;
    logic                  latched_vcxo_pll_locked_r, latched_vcxo_pll_locked_nxt;
    logic [N-1:0]          latched_input_active_r,    latched_input_active_nxt;
    logic                  latched_reference_ok_r,    latched_reference_ok_nxt;
    logic                  latched_not_holdover_r,    latched_not_holdover_nxt;
    logic                  irq_r,                     irq_nxt;

    // Write decode
    logic wr_lock, wr_ref, wr_en_lock, wr_en_ref;
    logic [7:0] wd;
    assign wd         = reg_req_in.wdata;
    assign wr_en_lock = reg_req_in.wr_en && reg_req_in.addr == pll_status_pkg::REG_IRQ_EN_LOCK_INPUTS;
    assign wr_en_ref  = reg_req_in.wr_en && reg_req_in.addr == pll_status_pkg::REG_IRQ_EN_REF_HOLDOVER;
    assign wr_lock    = reg_req_in.wr_en && reg_req_in.addr == pll_status_pkg::REG_LATCHED_LOCK_INPUTS;
    assign wr_ref     = reg_req_in.wr_en && reg_req_in.addr == pll_status_pkg::REG_LATCHED_REF_HOLDOVER;

    // Enable registers: plain read/write of the defined bits
    always_comb begin
        irq_en_out_pll_unlock_nxt  = irq_en_out_pll_unlock_r;
        irq_en_vcxo_pll_unlock_nxt = irq_en_vcxo_pll_unlock_r;
        irq_en_input_los_nxt       = irq_en_input_los_r;
        irq_en_reference_nxt       = irq_en_reference_r;
        irq_en_holdover_nxt        = irq_en_holdover_r;
        if (wr_en_lock) begin
            irq_en_out_pll_unlock_nxt  = wd[pll_status_pkg::BIT_OUT_PLL];
            irq_en_vcxo_pll_unlock_nxt = wd[pll_status_pkg::BIT_VCXO_PLL];
            irq_en_input_los_nxt       = wd[pll_status_pkg::BIT_INPUT0 +: N];
        end
        if (wr_en_ref) begin
            irq_en_reference_nxt = wd[pll_status_pkg::BIT_REFERENCE];
            irq_en_holdover_nxt  = wd[pll_status_pkg::BIT_HOLDOVER];
        end
    end

    // Latches: a fault in the same cycle as a clear wins, so no event is lost
    always_comb begin
        latched_out_pll_locked_nxt  = latched_out_pll_locked_r;
        latched_vcxo_pll_locked_nxt = latched_vcxo_pll_locked_r;
        latched_reference_ok_nxt    = latched_reference_ok_r;
        latched_not_holdover_nxt    = latched_not_holdover_r;
        if (wr_lock && wd[pll_status_pkg::BIT_OUT_PLL]) begin
            latched_out_pll_locked_nxt = pll_status_pkg::LATCH_CLEAN;
        end
        if (wr_lock && wd[pll_status_pkg::BIT_VCXO_PLL]) begin
            latched_vcxo_pll_locked_nxt = pll_status_pkg::LATCH_CLEAN;
        end
        if (wr_ref && wd[pll_status_pkg::BIT_REFERENCE]) begin
            latched_reference_ok_nxt = pll_status_pkg::LATCH_CLEAN;
        end
        if (wr_ref && wd[pll_status_pkg::BIT_HOLDOVER]) begin
            latched_not_holdover_nxt = pll_status_pkg::LATCH_CLEAN;
        end
        if (!live.out_pll_locked) begin
            latched_out_pll_locked_nxt = 1'b0;
        end
        if (!live.vcxo_pll_locked) begin
            latched_vcxo_pll_locked_nxt = 1'b0;
        end
        if (!live.reference_ok) begin
            latched_reference_ok_nxt = 1'b0;
        end
        if (!live.not_holdover) begin
            latched_not_holdover_nxt = 1'b0;
        end
    end

    // Per-input activity latches
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_input
            always_comb begin
                latched_input_active_nxt[g] = latched_input_active_r[g];
                if (wr_lock && wd[pll_status_pkg::BIT_INPUT0 + g]) begin
                    latched_input_active_nxt[g] = pll_status_pkg::LATCH_CLEAN;
                end
                if (!live.input_active[g]) begin
                    latched_input_active_nxt[g] = 1'b0;
                end
            end
        end
    endgenerate

    // Interrupt: any enabled pending latch holds the pin low
    always_comb begin
        irq_nxt = (irq_en_out_pll_unlock_r  && !latched_out_pll_locked_r)
               || (irq_en_vcxo_pll_unlock_r && !latched_vcxo_pll_locked_r)
               || (|(irq_en_input_los_r & ~latched_input_active_r))
               || (irq_en_reference_r       && !latched_reference_ok_r)
               || (irq_en_holdover_r        && !latched_not_holdover_r);
    end

    // Registers
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            irq_en_out_pll_unlock_r   <= 1'b0;
            irq_en_vcxo_pll_unlock_r  <= 1'b0;
            irq_en_input_los_r        <= '0;
            irq_en_reference_r        <= 1'b0;
            irq_en_holdover_r         <= 1'b0;
            latched_out_pll_locked_r  <= pll_status_pkg::LATCH_CLEAN;
            latched_vcxo_pll_locked_r <= pll_status_pkg::LATCH_CLEAN;
            latched_input_active_r    <= {N{pll_status_pkg::LATCH_CLEAN}};
            latched_reference_ok_r    <= pll_status_pkg::LATCH_CLEAN;
            latched_not_holdover_r    <= pll_status_pkg::LATCH_CLEAN;
            irq_r                     <= 1'b0;
        end else begin
            irq_en_out_pll_unlock_r   <= irq_en_out_pll_unlock_nxt;
            irq_en_vcxo_pll_unlock_r  <= irq_en_vcxo_pll_unlock_nxt;
            irq_en_input_los_r        <= irq_en_input_los_nxt;
            irq_en_reference_r        <= irq_en_reference_nxt;
            irq_en_holdover_r         <= irq_en_holdover_nxt;
            latched_out_pll_locked_r  <= latched_out_pll_locked_nxt;
            latched_vcxo_pll_locked_r <= latched_vcxo_pll_locked_nxt;
            latched_input_active_r    <= latched_input_active_nxt;
            latched_reference_ok_r    <= latched_reference_ok_nxt;
            latched_not_holdover_r    <= latched_not_holdover_nxt;
            irq_r                     <= irq_nxt;
        end
    end

    // Registered pin keeps glitches off the host's line
    assign irq_out_low_n_out = ~irq_r;

    // Read mux, reserved bits read zero; unmapped reads zero
    logic [7:0] rdata_nxt, rdata_r;
    always_comb begin
        rdata_nxt = 8'h00;
        case (reg_req_in.addr)
            pll_status_pkg::REG_IRQ_EN_LOCK_INPUTS: begin
                rdata_nxt[pll_status_pkg::BIT_OUT_PLL]        = irq_en_out_pll_unlock_r;
                rdata_nxt[pll_status_pkg::BIT_VCXO_PLL]       = irq_en_vcxo_pll_unlock_r;
                rdata_nxt[pll_status_pkg::BIT_INPUT0 +: N]    = irq_en_input_los_r;
            end
            pll_status_pkg::REG_IRQ_EN_REF_HOLDOVER: begin
                rdata_nxt[pll_status_pkg::BIT_REFERENCE] = irq_en_reference_r;
                rdata_nxt[pll_status_pkg::BIT_HOLDOVER]  = irq_en_holdover_r;
            end
            pll_status_pkg::REG_LATCHED_LOCK_INPUTS: begin
                rdata_nxt[pll_status_pkg::BIT_OUT_PLL]     = latched_out_pll_locked_r;
                rdata_nxt[pll_status_pkg::BIT_VCXO_PLL]    = latched_vcxo_pll_locked_r;
                rdata_nxt[pll_status_pkg::BIT_INPUT0 +: N] = latched_input_active_r;
            end
            pll_status_pkg::REG_LIVE_SEL_LOCK_INPUTS: begin
                rdata_nxt[pll_status_pkg::BIT_SEL_LO +: 2] = live.selected_input;
                rdata_nxt[pll_status_pkg::BIT_OUT_PLL]     = live.out_pll_locked;
                rdata_nxt[pll_status_pkg::BIT_VCXO_PLL]    = live.vcxo_pll_locked;
                rdata_nxt[pll_status_pkg::BIT_INPUT0 +: N] = live.input_active;
            end
            pll_status_pkg::REG_LATCHED_REF_HOLDOVER: begin
                rdata_nxt[pll_status_pkg::BIT_REFERENCE] = latched_reference_ok_r;
                rdata_nxt[pll_status_pkg::BIT_HOLDOVER]  = latched_not_holdover_r;
            end
            pll_status_pkg::REG_LIVE_CAL_REF_HOLDOVER: begin
                rdata_nxt[pll_status_pkg::BIT_CALIBRATING] = live.calibrating;
                rdata_nxt[pll_status_pkg::BIT_REFERENCE]   = live.reference_ok;
                rdata_nxt[pll_status_pkg::BIT_HOLDOVER]    = live.not_holdover;
            end
            default: begin
                rdata_nxt = 8'h00;
            end
        endcase
    end

    // Read data registered one cycle after the address
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata_out = rdata_r;

endmodule : pll_status_interrupt_logic

// *** rtl/pll_status_pkg.sv ***
// Package: register map, field positions and carriers of the PLL status block
package pll_status_pkg;

    // Register offsets on the serial port
    localparam logic [7:0] REG_IRQ_EN_LOCK_INPUTS  = 8'h68;
    localparam logic [7:0] REG_IRQ_EN_REF_HOLDOVER = 8'h69;
    localparam logic [7:0] REG_LATCHED_LOCK_INPUTS = 8'h6C;
    localparam logic [7:0] REG_LIVE_SEL_LOCK_INPUTS = 8'h6D;
    localparam logic [7:0] REG_LATCHED_REF_HOLDOVER = 8'h6E;
    localparam logic [7:0] REG_LIVE_CAL_REF_HOLDOVER = 8'h6F;

    // Field positions, lock/inputs registers
    localparam int BIT_INPUT0      = 0;
    localparam int BIT_VCXO_PLL    = 4;
    localparam int BIT_OUT_PLL     = 5;
    localparam int BIT_SEL_LO      = 6;
    // Field positions, reference/holdover registers
    localparam int BIT_HOLDOVER    = 0;
    localparam int BIT_REFERENCE   = 1;
    localparam int BIT_CALIBRATING = 2;

    localparam int NUM_INPUTS = 2;

    // Values after reset
    localparam logic [7:0] IRQ_EN_RESET  = 8'h00;
    localparam logic       LATCH_CLEAN   = 1'b1;

    // Write masks of the writable fields
    localparam logic [7:0] MASK_LOCK_INPUTS = 8'h33;
    localparam logic [7:0] MASK_REF_HOLD    = 8'h03;

    // Flop stages of the pin synchroniser, ahead of its filter register
    localparam int SYNC_STAGES = 3;

    // Live status as seen from the analog side
    typedef struct packed {
        logic                  out_pll_locked;
        logic                  vcxo_pll_locked;
        logic [NUM_INPUTS-1:0] input_active;
        logic                  reference_ok;
        logic                  not_holdover;
        logic                  calibrating;
        logic [1:0]            selected_input;
    } live_status_t;

    // Register access from the serial port engine
    typedef struct packed {
        logic       wr_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

endpackage : pll_status_pkg

// *** rtl/status_sync.sv ***
// Three-stage synchroniser with second/third agreement filter
module status_sync #(
    parameter int         WIDTH     = 1,
    parameter logic [0:0] RESET_VAL = 1'b0
) (
    // Clock and reset
    input  wire logic             ref_clk_in,
    input  wire logic             reset_n_in,
    // Asynchronous level in, filtered level out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] level_out
);

    logic [WIDTH-1:0] stage1_r;
    logic [WIDTH-1:0] stage2_r;
    logic [WIDTH-1:0] stage3_r;
    logic [WIDTH-1:0] level_r;
    logic [WIDTH-1:0] level_nxt;

    // Accept a change only once stages two and three agree
    always_comb begin
        level_nxt = level_r;
        for (int i = 0; i < WIDTH; i++) begin
            if (stage2_r[i] == stage3_r[i]) begin
                level_nxt[i] = stage3_r[i];
            end
        end
    end

    // Stage one feeds only stage two, avoiding metastable fan-out
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            stage1_r <= {WIDTH{RESET_VAL}};
            stage2_r <= {WIDTH{RESET_VAL}};
            stage3_r <= {WIDTH{RESET_VAL}};
            level_r  <= {WIDTH{RESET_VAL}};
        end else begin
            stage1_r <= async_in;
            stage2_r <= stage1_r;
            stage3_r <= stage2_r;
            level_r  <= level_nxt;
        end
    end

    assign level_out = level_r;

endmodule : status_sync

// *** verif/pll_status_assertions.sv ***
// Port-level checks of the PLL status interrupt block
module pll_status_assertions (
    // Clock and reset
    input wire logic                         ref_clk_in,
    input wire logic                         reset_n_in,
    // Watched ports
    input wire pll_status_pkg::live_status_t live_status_in,
    input wire pll_status_pkg::reg_req_t     reg_req_in,
    input wire logic [7:0]                   reg_rdata_out,
    input wire logic                         irq_out_low_n_out
);
    logic [7:0]                   en_lock_r, en_lock_nxt, en_ref_r, en_ref_nxt;
    logic [3:0]                   quiet_r, quiet_nxt;
    pll_status_pkg::live_status_t live_q_r;
    logic                         fault_en, unmapped, settled;

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);

    // Mirror of enables and age of the live levels
    always_comb begin
        en_lock_nxt = en_lock_r;
        en_ref_nxt  = en_ref_r;
        quiet_nxt   = (live_status_in != live_q_r) ? 4'h0 : quiet_r + {3'h0, quiet_r != 4'hF};
        if (reg_req_in.wr_en && reg_req_in.addr == pll_status_pkg::REG_IRQ_EN_LOCK_INPUTS)
            en_lock_nxt = reg_req_in.wdata & pll_status_pkg::MASK_LOCK_INPUTS;
        if (reg_req_in.wr_en && reg_req_in.addr == pll_status_pkg::REG_IRQ_EN_REF_HOLDOVER)
            en_ref_nxt = reg_req_in.wdata & pll_status_pkg::MASK_REF_HOLD;
        fault_en = |(~{2'h3, live_status_in.out_pll_locked, live_status_in.vcxo_pll_locked,
                       2'h3, live_status_in.input_active} & en_lock_r)
                 | |(~{6'h3F, live_status_in.reference_ok, live_status_in.not_holdover} & en_ref_r);
        unmapped = !(reg_req_in.addr inside {8'h68, 8'h69, [8'h6C:8'h6F]});
        // Live levels old enough to have crossed the synchroniser, no fresh change
        settled  = quiet_r >= 4'h8 && live_status_in == live_q_r;
    end

    // Helper registers, cleared with the design
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            en_lock_r <= 8'h00;
            en_ref_r  <= 8'h00;
            quiet_r   <= 4'h0;
            live_q_r  <= '0;
        end else begin
            en_lock_r <= en_lock_nxt;
            en_ref_r  <= en_ref_nxt;
            quiet_r   <= quiet_nxt;
            live_q_r  <= live_status_in;
        end
    end

    property p_irq_idle;
        (en_lock_r == 8'h00 && en_ref_r == 8'h00) [*3] |-> irq_out_low_n_out;
    endproperty
    a_irq_idle: assert property (p_irq_idle) else $error("irq low with all enables off");
    property p_irq_fault;
        (settled && fault_en && $stable(en_lock_r) && $stable(en_ref_r))
            |=> !irq_out_low_n_out;
    endproperty
    a_irq_fault: assert property (p_irq_fault) else $error("enabled fault gave no irq");
    property p_unmapped;
        unmapped |=> reg_rdata_out == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_en_lock_rb;
        (reg_req_in.addr == 8'h68 && !reg_req_in.wr_en && !$past(reg_req_in.wr_en))
            |=> reg_rdata_out == en_lock_r;
    endproperty
    a_en_lock_rb: assert property (p_en_lock_rb) else $error("lock enable readback");
    property p_en_ref_rb;
        (reg_req_in.addr == 8'h69 && !reg_req_in.wr_en) |=> reg_rdata_out == en_ref_r;
    endproperty
    a_en_ref_rb: assert property (p_en_ref_rb) else $error("ref enable readback");
    property p_lock_rsvd;
        reg_req_in.addr == 8'h6C |=> (reg_rdata_out & 8'hCC) == 8'h00;
    endproperty
    a_lock_rsvd: assert property (p_lock_rsvd) else $error("latch reserved bits set");
    property p_ref_rsvd;
        reg_req_in.addr == 8'h6E |=> reg_rdata_out[7:2] == 6'h00;
    endproperty
    a_ref_rsvd: assert property (p_ref_rsvd) else $error("ref latch reserved bits");
    property p_live_lock;
        (settled && reg_req_in.addr == 8'h6D) |=> reg_rdata_out ==
            {live_q_r.selected_input, live_q_r.out_pll_locked,
             live_q_r.vcxo_pll_locked, 2'h0, live_q_r.input_active};
    endproperty
    a_live_lock: assert property (p_live_lock) else $error("live lock read wrong");
    property p_live_cal;
        (settled && reg_req_in.addr == 8'h6F) |=> reg_rdata_out ==
            {5'h00, live_q_r.calibrating, live_q_r.reference_ok,
             live_q_r.not_holdover};
    endproperty
    a_live_cal: assert property (p_live_cal) else $error("live cal read wrong");

    // Main scenarios reached
    c_irq: cover property (!irq_out_low_n_out);
    c_clear: cover property (reg_req_in.wr_en && reg_req_in.addr == 8'h6C);
    c_live: cover property (quiet_r >= 4'h8 && reg_req_in.addr == 8'h6D);
endmodule : pll_status_assertions

bind pll_status_interrupt_logic pll_status_assertions pll_status_assertions_i (
    .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .live_status_in(live_status_in),
    .reg_req_in(reg_req_in), .reg_rdata_out(reg_rdata_out),
    .irq_out_low_n_out(irq_out_low_n_out));

// *** verif/host_model.sv ***
// Host side register access model, drives at the falling edge
module host_model (
    input  wire logic                     ref_clk_in,
    input  wire logic [7:0]               rdata_in,
    output pll_status_pkg::reg_req_t      req_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial req_out = '0;
    // One-cycle write strobe, address held after it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk_in);
        req_out = '{1'b1, a, d};
        @(negedge ref_clk_in);
        req_out.wr_en = 1'b0;
    endtask : wr
    // Two edges pass so registered data has settled
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge ref_clk_in);
        req_out = '{1'b0, a, 8'h00};
        repeat (2) @(negedge ref_clk_in);
        d = rdata_in;
    endtask : rd
    // Write-one clear of both latch registers
    task automatic clear_all();
        wr(pll_status_pkg::REG_LATCHED_LOCK_INPUTS, 8'h33);
        wr(pll_status_pkg::REG_LATCHED_REF_HOLDOVER, 8'h03);
    endtask : clear_all
endmodule : host_model

// *** verif/pll_status_interrupt_logic_test.sv ***
// Self-checking bench of the PLL status interrupt block
`define CHK(what, exp, got) begin check_count++; if ((got) !== (exp)) begin failures++; \
    $display("mismatch %s expected %h seen %h", what, exp, got); end end
module pll_status_interrupt_logic_test;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [8:0] live;
        logic [7:0] en_lock, en_ref, lat_lock, sel_lock, lat_ref, cal_ref;
        logic       irq_n;
    } row_t;
    localparam logic [8:0] HEALTHY = 9'h1F8;
    // Live levels, enables, expected reads and pin
    localparam row_t ROWS [9] = '{
        '{9'h0F8, 8'h20, 8'h00, 8'h13, 8'h13, 8'h03, 8'h03, 1'b0},
        '{9'h0F8, 8'h10, 8'h03, 8'h13, 8'h13, 8'h03, 8'h03, 1'b1},
        '{9'h178, 8'h10, 8'h00, 8'h23, 8'h23, 8'h03, 8'h03, 1'b0},
        '{9'h1B9, 8'h02, 8'h00, 8'h31, 8'h71, 8'h03, 8'h03, 1'b0},
        '{9'h1D8, 8'h02, 8'h00, 8'h32, 8'h32, 8'h03, 8'h03, 1'b1},
        '{9'h1D8, 8'h01, 8'h00, 8'h32, 8'h32, 8'h03, 8'h03, 1'b0},
        '{9'h1E8, 8'h00, 8'h02, 8'h33, 8'h33, 8'h01, 8'h01, 1'b0},
        '{9'h1F0, 8'h00, 8'h01, 8'h33, 8'h33, 8'h02, 8'h02, 1'b0},
        '{9'h1FC, 8'h33, 8'h03, 8'h33, 8'h33, 8'h03, 8'h07, 1'b1}};
    logic                         ref_clk_in, reset_n_in, irq_n;
    pll_status_pkg::live_status_t live;
    pll_status_pkg::reg_req_t     req;
    logic [7:0]                   rdata, d;
    int                           failures, check_count, cycles;

    pll_status_interrupt_logic pll_status_interrupt_logic_i (.ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in), .live_status_in(live), .reg_req_in(req),
        .reg_rdata_out(rdata), .irq_out_low_n_out(irq_n));
    host_model host_model_i (.ref_clk_in(ref_clk_in), .rdata_in(rdata), .req_out(req));

    // Clock and hang guard
    initial begin
        ref_clk_in = 1'b0;
        forever #2.5 ref_clk_in = ~ref_clk_in;
    end
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            results();
        end
    end

    task automatic results();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results
    // Sync path needs about four edges; ten leaves margin
    task automatic set_live(input logic [8:0] v, input int hold);
        @(negedge ref_clk_in);
        live = v;
        repeat (hold) @(negedge ref_clk_in);
    endtask : set_live
    task automatic do_reset(input int n);
        @(negedge ref_clk_in);
        reset_n_in = 1'b0;
        repeat (n) @(negedge ref_clk_in);
        reset_n_in = 1'b1;
        repeat (8) @(negedge ref_clk_in);
    endtask : do_reset

    initial begin
        reset_n_in = 1'b0;
        live = HEALTHY;
        do_reset(7);
        host_model_i.rd(8'h68, d); `CHK("enable lock", 8'h00, d)
        host_model_i.rd(8'h69, d); `CHK("enable ref", 8'h00, d)
        `CHK("irq after reset", 1'b1, irq_n)
        host_model_i.clear_all();
        // Table of single faults against each enable
        foreach (ROWS[i]) begin
            host_model_i.wr(8'h68, ROWS[i].en_lock);
            host_model_i.wr(8'h69, ROWS[i].en_ref);
            set_live(ROWS[i].live, 10);
            host_model_i.rd(8'h6C, d); `CHK("latched lock", ROWS[i].lat_lock, d)
            host_model_i.rd(8'h6D, d); `CHK("live lock", ROWS[i].sel_lock, d)
            host_model_i.rd(8'h6E, d); `CHK("latched ref", ROWS[i].lat_ref, d)
            host_model_i.rd(8'h6F, d); `CHK("live cal", ROWS[i].cal_ref, d)
            `CHK("irq row", ROWS[i].irq_n, irq_n)
            set_live(HEALTHY, 10);
            host_model_i.clear_all();
            host_model_i.rd(8'h6C, d); `CHK("cleared lock", 8'h33, d)
            host_model_i.rd(8'h6E, d); `CHK("cleared ref", 8'h03, d)
            `CHK("irq cleared", 1'b1, irq_n)
        end
        // Unmapped reads and writes to read-only places
        host_model_i.rd(8'h70, d); `CHK("unmapped", 8'h00, d)
        host_model_i.wr(8'h6D, 8'h00);
        host_model_i.rd(8'h6D, d); `CHK("read only", 8'h33, d)
        // Clear under a standing fault, then two pending latches
        host_model_i.wr(8'h68, 8'h30);
        set_live(9'h0F8, 10);
        host_model_i.wr(8'h6C, 8'h20);
        host_model_i.rd(8'h6C, d); `CHK("fault wins", 8'h13, d)
        set_live(HEALTHY, 2);
        set_live(9'h178, 2);
        set_live(HEALTHY, 10);
        host_model_i.rd(8'h6C, d); `CHK("short pulse", 8'h03, d)
        host_model_i.wr(8'h6C, 8'h10);
        repeat (3) @(negedge ref_clk_in);
        `CHK("irq one pending", 1'b0, irq_n)
        host_model_i.rd(8'h6C, d); `CHK("vcxo cleared", 8'h13, d)
        host_model_i.wr(8'h6C, 8'h20);
        repeat (3) @(negedge ref_clk_in);
        `CHK("irq none pending", 1'b1, irq_n)
        // Reset in mid-run clears the enables
        do_reset(3);
        host_model_i.rd(8'h68, d); `CHK("enable after reset", 8'h00, d)
        `CHK("irq after second reset", 1'b1, irq_n)
        results();
    end
endmodule : pll_status_interrupt_logic_test
